/* design/device_mode_transition_ctrl.sv */
// Purpose: device mode state machine with software development variant
// Assumes: frame, watchdog and config inputs come from logic on i_clk
// Notes: fail-safe is only left by power-on; supply pins are synchronised
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - dev mode: watchdog failure never forces restart
// RULE2 - dev mode: CAN/LIN default on in init
// RULE3 - dev mode: watchdog on, wrong trigger pulses interrupt
// RULE4 - watchdog disable: no interrupt, no failure flag
// RULE5 - mask bit leaves only the failure flag
// RULE6 - short in init blocks dev mode
// RULE7 - power-up or soft reset enters init, reloads
// RULE8 - soft reset pulses reset unless select set
// RULE9 - reset held low below threshold, then delay
// RULE10 - undervoltage flag/restart only after first release
// RULE11 - wake events in init are discarded
// RULE12 - init: supply flag updates after reset high
// RULE13 - any valid frame in window enters normal
// RULE14 - sleep or bad frame in init: flag failure
// RULE15 - stop by command; interrupt if wake pending
// RULE16 - sleep from stop: failure flag, restart
// RULE17 - sleep without wake source: failure, restart
// RULE18 - sleep command drives reset low at once
// RULE19 - faults at sleep entry take priority
// RULE20 - stop to normal only by command
// RULE21 - sleep wake goes restart, records source
// RULE22 - reset release: restart to normal, watchdog window
module device_mode_transition_ctrl #(
  parameter int unsigned LONG_OPEN_CYCLES = dmtc_pkg::LONG_OPEN_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // supply and fault pins
  input wire logic i_main_reg_ok,
  input wire logic i_supply_ok,
  input wire logic i_main_reg_uv,
  input wire logic i_main_reg_ov,
  input wire logic i_thermal_shutdown_event,
  input wire logic i_main_reg_short,
  input wire logic i_dev_mode_select,
  input wire logic [dmtc_pkg::WAKE_W-1:0] i_wake,
  // frame from the serial interface
  input wire logic i_frame_valid,
  input wire logic [1:0] i_frame_mode,
  input wire logic i_frame_content_bad,
  // configuration
  input wire logic i_ov_to_failsafe,
  input wire logic i_soft_reset_reset_select,
  input wire logic i_dev_watchdog_disable,
  input wire logic i_dev_watchdog_irq_mask,
  input wire logic i_wake_sources_enabled,
  input wire logic i_wake_flags_pending,
  input wire logic i_wd_trigger_fail,
  input wire logic [dmtc_pkg::FLAG_W-1:0] i_flag_clear,
  input wire logic [dmtc_pkg::WAKE_W-1:0] i_wake_status_clear,
  // pins to host
  output logic o_reset_out_n,
  output logic o_interrupt_out_n,
  // status
  output dmtc_pkg::dev_mode_type o_mode,
  output logic o_dev_mode_active,
  output logic o_can_lin_default_on,
  output logic o_watchdog_enabled,
  output logic [dmtc_pkg::FLAG_W-1:0] o_flags,
  output logic [dmtc_pkg::WAKE_W-1:0] o_wake_status,
  output logic o_soft_reset_load,
  output logic o_wd_restart
);
  typedef struct packed {
    logic [dmtc_pkg::PIN_W-1:0] s1;
    logic [dmtc_pkg::PIN_W-1:0] s2;
    dmtc_pkg::dev_mode_type st;
    logic dev;
    logic ever_rel;
    logic wd_en;
    logic can_lin;
    logic [dmtc_pkg::FLAG_W-1:0] flags;
    logic [dmtc_pkg::WAKE_W-1:0] wake_stat;
    logic int_n;
    logic [dmtc_pkg::INT_CNT_W-1:0] int_cnt;
    logic open;
    logic [dmtc_pkg::OPEN_CNT_W-1:0] open_cnt;
    logic soft_load;
    logic wd_restart;
  } ctrl_state_type;
  ctrl_state_type q, d;

  rst_ctrl_if rc ();

  logic main_ok, supply_ok, main_uv, main_ov, thermal, short_gnd, dev_sel;
  logic [dmtc_pkg::WAKE_W-1:0] wake;
  logic fault_fs, fault_rs, wd_act, wd_evt, wd_forces, int_req, pulse_req;

  function automatic logic frame_is(input logic v, input logic [1:0] m, input logic [1:0] code);
    return v && (m == code);
  endfunction

  // only the second stage of each synchroniser is looked at
  assign main_ok = q.s2[dmtc_pkg::PIN_MAIN_OK];
  assign supply_ok = q.s2[dmtc_pkg::PIN_SUPPLY_OK];
  assign main_uv = q.s2[dmtc_pkg::PIN_MAIN_UV];
  assign main_ov = q.s2[dmtc_pkg::PIN_MAIN_OV];
  assign thermal = q.s2[dmtc_pkg::PIN_THERMAL];
  assign short_gnd = q.s2[dmtc_pkg::PIN_SHORT];
  assign dev_sel = q.s2[dmtc_pkg::PIN_DEV_SEL];
  assign wake = q.s2[dmtc_pkg::PIN_WAKE +: dmtc_pkg::WAKE_W];

  assign fault_fs = thermal || short_gnd || (main_ov && i_ov_to_failsafe);
  assign fault_rs = (main_uv && q.ever_rel) || (main_ov && !i_ov_to_failsafe); // [RULE10]
  assign wd_act = !(q.dev && i_dev_watchdog_disable); // [RULE4]
  assign wd_evt = i_wd_trigger_fail ||
    (q.st == dmtc_pkg::ST_INIT && q.open && q.open_cnt == '0);
  assign wd_forces = wd_evt && wd_act && !q.dev; // [RULE1]

  always_comb begin
    d = q;
    d.s1 = {i_wake, i_dev_mode_select, i_main_reg_short, i_thermal_shutdown_event,
            i_main_reg_ov, i_main_reg_uv, i_supply_ok, i_main_reg_ok};
    d.s2 = q.s1;
    d.soft_load = 1'b0;
    d.wd_restart = 1'b0;
    int_req = 1'b0;
    pulse_req = 1'b0;
    // hardware set wins over a clear in the same cycle
    d.flags = q.flags & ~i_flag_clear;
    d.wake_stat = q.wake_stat & ~i_wake_status_clear;
    if (wd_evt && wd_act) begin
      d.flags[dmtc_pkg::FLAG_WATCHDOG_FAILURE_FLAG] = 1'b1; // [RULE4]
      int_req = q.dev && !i_dev_watchdog_irq_mask; // [RULE3] [RULE5]
    end
    if (main_uv && q.ever_rel) begin
      d.flags[dmtc_pkg::FLAG_MAIN_UV] = 1'b1; // [RULE10]
    end
    if (!supply_ok && (q.st != dmtc_pkg::ST_INIT || rc.rst_high)) begin
      d.flags[dmtc_pkg::FLAG_SUPPLY_UV] = 1'b1; // [RULE12]
    end
    // long open window runs from each reset rising edge
    if (rc.released) begin
      d.ever_rel = 1'b1; // [RULE10]
      d.open = 1'b1;
      d.open_cnt = dmtc_pkg::OPEN_CNT_W'(LONG_OPEN_CYCLES - 1); // [RULE22]
    end else if (q.open) begin
      if (q.open_cnt == '0) begin
        d.open = 1'b0;
      end else begin
        d.open_cnt = q.open_cnt - 1'b1;
      end
    end
    // the development strap is followed until the first reset release
    if (q.st == dmtc_pkg::ST_INIT && !q.ever_rel && !short_gnd) begin
      d.dev = dev_sel;
    end
    unique case (q.st)
      dmtc_pkg::ST_INIT: begin
        // wake inputs are not looked at here, so they are lost [RULE11]
        if (short_gnd) begin
          d.st = dmtc_pkg::ST_FAILSAFE;
          d.dev = 1'b0; // [RULE6]
        end else if (thermal) begin
          d.st = dmtc_pkg::ST_FAILSAFE;
        end else if (i_frame_valid && rc.rst_high && q.open) begin
          d.st = dmtc_pkg::ST_NORMAL; // [RULE13]
          d.open = 1'b0;
          if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SLEEP) ||
              i_frame_content_bad) begin
            d.flags[dmtc_pkg::FLAG_SPI_FAIL] = 1'b1; // [RULE14]
          end
        end
      end
      dmtc_pkg::ST_NORMAL, dmtc_pkg::ST_STOP: begin
        // faults are checked before any command, also at sleep entry [RULE19]
        if (fault_fs) begin
          d.st = dmtc_pkg::ST_FAILSAFE;
        end else if (fault_rs || wd_forces) begin
          d.st = dmtc_pkg::ST_RESTART; // [RULE1]
        end else if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SOFT_RESET)) begin
          d.st = dmtc_pkg::ST_INIT; // [RULE7]
          d.soft_load = 1'b1;
          d.flags = dmtc_pkg::FLAGS_RESET;
          d.wake_stat = dmtc_pkg::WAKE_RESET;
          d.open = 1'b1;
          d.open_cnt = dmtc_pkg::OPEN_CNT_W'(LONG_OPEN_CYCLES - 1);
          pulse_req = !i_soft_reset_reset_select; // [RULE8]
        end else if (q.st == dmtc_pkg::ST_NORMAL) begin
          if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_STOP)) begin
            d.st = dmtc_pkg::ST_STOP; // [RULE15]
            // a watchdog event in the same cycle keeps its pulse
            int_req = int_req || i_wake_flags_pending;
          end else if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SLEEP)) begin
            if (!i_wake_sources_enabled) begin
              d.st = dmtc_pkg::ST_RESTART; // [RULE17]
              d.flags[dmtc_pkg::FLAG_SPI_FAIL] = 1'b1;
            end else begin
              d.st = dmtc_pkg::ST_SLEEP;
            end
          end
        end else if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_NORMAL)) begin
          d.st = dmtc_pkg::ST_NORMAL; // [RULE20]
        end else if (frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SLEEP)) begin
          d.st = dmtc_pkg::ST_RESTART; // [RULE16]
          d.flags[dmtc_pkg::FLAG_SPI_FAIL] = 1'b1;
        end
      end
      dmtc_pkg::ST_SLEEP: begin
        if (thermal) begin
          d.st = dmtc_pkg::ST_FAILSAFE;
        end else if (|wake) begin
          d.st = dmtc_pkg::ST_RESTART; // [RULE21]
          d.wake_stat = d.wake_stat | wake;
        end
      end
      dmtc_pkg::ST_RESTART: begin
        if (rc.released) begin
          d.st = dmtc_pkg::ST_NORMAL; // [RULE22]
          d.wd_restart = 1'b1;
        end
      end
      dmtc_pkg::ST_FAILSAFE: begin
      end
      default: begin
        d.st = dmtc_pkg::ST_INIT;
      end
    endcase
    if (d.st == dmtc_pkg::ST_RESTART && q.st != dmtc_pkg::ST_RESTART) begin
      d.flags[dmtc_pkg::FLAG_RESTART] = 1'b1; // [RULE21]
    end
    if (d.st == dmtc_pkg::ST_INIT) begin
      d.can_lin = d.dev; // [RULE2]
    end
    d.wd_en = !(d.dev && i_dev_watchdog_disable); // [RULE3]
    // interrupt pulse; a new request restarts it
    if (int_req) begin
      d.int_n = 1'b0;
      d.int_cnt = dmtc_pkg::INT_CNT_W'(dmtc_pkg::INT_PULSE_CYCLES - 1);
    end else if (!q.int_n) begin
      if (q.int_cnt == '0) begin
        d.int_n = 1'b1;
      end else begin
        d.int_cnt = q.int_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // reset falls at the same edge as the sleep entry [RULE18]
  // restart entry only pulses it low, so the delay counter can release it [RULE21] [RULE22]
  assign rc.hold_low = !main_ok || d.st == dmtc_pkg::ST_SLEEP ||
    (d.st == dmtc_pkg::ST_RESTART && q.st != dmtc_pkg::ST_RESTART) ||
    d.st == dmtc_pkg::ST_FAILSAFE; // [RULE9]
  assign rc.pulse_req = pulse_req;

  reset_out_gen u_reset_out_gen (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .rc(rc),
    .o_reset_out_n(o_reset_out_n)
  );

  assign o_interrupt_out_n = q.int_n;
  assign o_mode = q.st;
  assign o_dev_mode_active = q.dev;
  assign o_can_lin_default_on = q.can_lin;
  assign o_watchdog_enabled = q.wd_en;
  assign o_flags = q.flags;
  assign o_wake_status = q.wake_stat;
  assign o_soft_reset_load = q.soft_load;
  assign o_wd_restart = q.wd_restart;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_DEV_WD_STAYS: assert property ( // [RULE1]
      (q.st == dmtc_pkg::ST_NORMAL && q.dev && !fault_fs && !fault_rs && !i_frame_valid)
      |=> q.st == dmtc_pkg::ST_NORMAL)
    else $error("dev mode left normal without cause");
  AST_WD_DISABLED: assert property ( // [RULE4]
      (q.dev && i_dev_watchdog_disable && !q.flags[dmtc_pkg::FLAG_WATCHDOG_FAILURE_FLAG])
      |=> !q.flags[dmtc_pkg::FLAG_WATCHDOG_FAILURE_FLAG])
    else $error("watchdog flag set while disabled");
  AST_WD_INT: assert property ( // [RULE3]
      (q.st == dmtc_pkg::ST_NORMAL && q.dev && i_wd_trigger_fail &&
      !i_dev_watchdog_disable && !i_dev_watchdog_irq_mask) |=> !o_interrupt_out_n)
    else $error("watchdog interrupt missing");
  AST_WAKE_INIT: assert property ( // [RULE11]
      (q.st == dmtc_pkg::ST_INIT && i_wake_status_clear == '0) |=> $stable(o_wake_status))
    else $error("wake recorded in init");
  AST_INIT_FRAME: assert property ( // [RULE13]
      (q.st == dmtc_pkg::ST_INIT && i_frame_valid && q.open && rc.rst_high && !fault_fs)
      |=> q.st == dmtc_pkg::ST_NORMAL)
    else $error("valid frame did not enter normal");
  AST_STOP_SLEEP: assert property ( // [RULE16]
      (q.st == dmtc_pkg::ST_STOP && !fault_fs && !fault_rs && !wd_forces &&
      frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SLEEP)) |=>
      q.st == dmtc_pkg::ST_RESTART && q.flags[dmtc_pkg::FLAG_SPI_FAIL])
    else $error("sleep from stop not refused");
  AST_SLEEP_RST: assert property ( // [RULE18]
      (q.st == dmtc_pkg::ST_NORMAL && !fault_fs && !fault_rs && !wd_forces &&
      i_wake_sources_enabled && frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SLEEP))
      |=> !o_reset_out_n)
    else $error("reset not low after sleep command");
  AST_SOFT_RST: assert property ( // [RULE8]
      (q.st == dmtc_pkg::ST_NORMAL && !fault_fs && !fault_rs && !wd_forces &&
      !i_soft_reset_reset_select &&
      frame_is(i_frame_valid, i_frame_mode, dmtc_pkg::MODE_SOFT_RESET)) |=>
      q.st == dmtc_pkg::ST_INIT ##1 !o_reset_out_n)
    else $error("soft reset pulse missing");
  COV_WAKE: cover property (q.st == dmtc_pkg::ST_SLEEP ##1 q.st == dmtc_pkg::ST_RESTART);
  COV_INIT_NORMAL: cover property (q.st == dmtc_pkg::ST_INIT ##1 q.st == dmtc_pkg::ST_NORMAL);
  COV_SOFT: cover property (q.soft_load);
endmodule // device_mode_transition_ctrl
`default_nettype wire

/* design/dmtc_pkg.sv */
// Purpose: shared constants and types of the device mode transition control
// Assumes: 250 MHz core clock
// Notes: times are given in ns and turned into cycle counts here
package dmtc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // least times round up to whole cycles
  localparam int RESET_DELAY_NS = 10000;
  localparam int RESET_DELAY_CYCLES = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_PULSE_NS = 100;
  localparam int INT_PULSE_CYCLES = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_OPEN_NS = 200000000;
  localparam int LONG_OPEN_CYCLES = LONG_OPEN_NS / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 12;
  localparam int INT_CNT_W = 5;
  localparam int OPEN_CNT_W = 32;
  // mode field codes of a frame
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  // wake source positions
  localparam int WAKE_W = 6;
  localparam int WAKE_CAN = 0;
  localparam int WAKE_LIN = 1;
  localparam int WAKE_INPUT = 2;
  localparam int WAKE_CSENSE = 3;
  localparam int WAKE_CWAKE = 4;
  localparam int WAKE_BRAKE = 5;
  // status flag positions
  localparam int FLAG_W = 5;
  localparam int FLAG_WATCHDOG_FAILURE_FLAG = 0;
  localparam int FLAG_MAIN_UV = 1;
  localparam int FLAG_SUPPLY_UV = 2;
  localparam int FLAG_SPI_FAIL = 3;
  localparam int FLAG_RESTART = 4;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
  localparam logic [WAKE_W-1:0] WAKE_RESET = 6'h00;
  // synchronised pin positions
  localparam int PIN_MAIN_OK = 0;
  localparam int PIN_SUPPLY_OK = 1;
  localparam int PIN_MAIN_UV = 2;
  localparam int PIN_MAIN_OV = 3;
  localparam int PIN_THERMAL = 4;
  localparam int PIN_SHORT = 5;
  localparam int PIN_DEV_SEL = 6;
  localparam int PIN_WAKE = 7;
  localparam int PIN_W = 13;
  typedef enum logic [2:0] {
    ST_INIT, ST_NORMAL, ST_STOP, ST_SLEEP, ST_RESTART, ST_FAILSAFE
  } dev_mode_type;
endpackage

/* design/reset_out_gen.sv */
// Purpose: drives the reset output and its release delay
// Assumes: hold_low already covers the main regulator threshold
// Notes: released is a one-cycle pulse on the rising edge of the output
`timescale 1ns/1ps
`default_nettype none
module reset_out_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control link
  rst_ctrl_if.gen rc,
  // pin
  output logic o_reset_out_n
);
  typedef struct packed {
    logic rst_n;
    logic released;
    logic [dmtc_pkg::RST_CNT_W-1:0] cnt;
  } gen_state_type;
  gen_state_type q, d;

  always_comb begin
    d = q;
    d.released = 1'b0;
    if (rc.hold_low || rc.pulse_req) begin
      d.rst_n = 1'b0;
      d.cnt = '0;
    end else if (!q.rst_n) begin
      // delay only counts while the regulator stays above threshold [RULE9]
      if (q.cnt == dmtc_pkg::RST_CNT_W'(dmtc_pkg::RESET_DELAY_CYCLES - 1)) begin
        d.rst_n = 1'b1;
        d.released = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_reset_out_n = q.rst_n;
  assign rc.rst_high = q.rst_n;
  assign rc.released = q.released;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_RST_HOLD: assert property (rc.hold_low |=> !o_reset_out_n) // [RULE9]
    else $error("reset output not held low");
  AST_RST_DELAY: assert property ( // [RULE9]
      $rose(o_reset_out_n) |->
      $past(q.cnt) == dmtc_pkg::RST_CNT_W'(dmtc_pkg::RESET_DELAY_CYCLES - 1))
    else $error("reset released before delay elapsed");
endmodule // reset_out_gen
`default_nettype wire

/* design/rst_ctrl_if.sv */
// Purpose: link between mode control and reset output generator
// Assumes: single clock domain
// Notes: hold_low and pulse_req come from the mode control
`timescale 1ns/1ps
`default_nettype none
interface rst_ctrl_if;
  logic hold_low;
  logic pulse_req;
  logic rst_high;
  logic released;
  modport ctrl (output hold_low, output pulse_req, input rst_high, input released);
  modport gen (input hold_low, input pulse_req, output rst_high, output released);
endinterface
`default_nettype wire

/* verification/host_model.sv */
// Purpose: host side model that sends mode frames and watches the pins
// Assumes: frames go out only while reset_out_n is high
// Notes: interrupt pulses are counted on their falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and pins from device
  input wire logic i_clk,
  input wire logic i_reset_out_n,
  input wire logic i_interrupt_out_n,
  // frame to device
  output logic o_frame_valid,
  output logic [1:0] o_frame_mode,
  output logic o_frame_content_bad,
  // wake housekeeping
  output logic o_wake_sources_enabled,
  output logic o_wake_flags_pending
);
  int irq_count = 0;
  initial begin
    o_frame_valid = 1'b0;
    o_frame_mode = 2'h0;
    o_frame_content_bad = 1'b0;
    o_wake_sources_enabled = 1'b1;
    o_wake_flags_pending = 1'b0;
  end
  always @(negedge i_interrupt_out_n) begin
    irq_count <= irq_count + 1;
  end
  // a random idle gap keeps the frame spacing varied
  task automatic send(input logic [1:0] mode, input logic bad);
    int gap;
    gap = $urandom_range(3, 0);
    repeat (gap + 1) @(posedge i_clk);
    while (i_reset_out_n !== 1'b1) @(posedge i_clk);
    #1;
    o_frame_valid = 1'b1; // one protocol-valid frame per request
    o_frame_mode = mode;
    o_frame_content_bad = bad;
    @(posedge i_clk);
    #1;
    o_frame_valid = 1'b0;
    o_frame_content_bad = ~bad;
  endtask
  task automatic wake_setup(input logic enabled, input logic pending);
    o_wake_sources_enabled = enabled; // wake source enable and pending flag set as given
    o_wake_flags_pending = pending;
  endtask
endmodule // host_model
`default_nettype wire

/* verification/tb.sv */
// Purpose: self-checking bench of the device mode transition control
// Assumes: short long-open window parameter, fixed reset delay
// Notes: expected values come from constants, task arguments, loop variables or exp_flags in each check of the bench
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, arst_n, main_ok, supply_ok, main_uv, thermal, short_gnd, dev_sel;
  logic [5:0] wake, wake_clr;
  logic [4:0] flag_clr, exp_flags;
  logic sel, wd_dis, wd_mask, watchdog_failure_flag, fv, fbad, wen, wpend, rst_n, irq_n;
  logic [1:0] fmode;
  logic ov, ovfs;
  logic dev_act, canlin, wd_en, load, wdr;
  logic [4:0] flags;
  logic [5:0] wstat;
  dmtc_pkg::dev_mode_type mode;
  int n_fail = 0, tests_run = 0, cycles = 0, loads = 0, wdrs = 0, irq0, k, b;
  device_mode_transition_ctrl #(.LONG_OPEN_CYCLES(64)) device_mode_transition_ctrl_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_main_reg_ok(main_ok), .i_supply_ok(supply_ok),
    .i_main_reg_uv(main_uv), .i_main_reg_ov(ov), .i_thermal_shutdown_event(thermal),
    .i_main_reg_short(short_gnd), .i_dev_mode_select(dev_sel), .i_wake(wake),
    .i_frame_valid(fv), .i_frame_mode(fmode), .i_frame_content_bad(fbad),
    .i_ov_to_failsafe(ovfs), .i_soft_reset_reset_select(sel),
    .i_dev_watchdog_disable(wd_dis), .i_dev_watchdog_irq_mask(wd_mask),
    .i_wake_sources_enabled(wen), .i_wake_flags_pending(wpend), .i_wd_trigger_fail(watchdog_failure_flag),
    .i_flag_clear(flag_clr), .i_wake_status_clear(wake_clr), .o_reset_out_n(rst_n),
    .o_interrupt_out_n(irq_n), .o_mode(mode), .o_dev_mode_active(dev_act),
    .o_can_lin_default_on(canlin), .o_watchdog_enabled(wd_en), .o_flags(flags),
    .o_wake_status(wstat), .o_soft_reset_load(load), .o_wd_restart(wdr));
  host_model host_model_inst (
    .i_clk(clk), .i_reset_out_n(rst_n), .i_interrupt_out_n(irq_n), .o_frame_valid(fv),
    .o_frame_mode(fmode), .o_frame_content_bad(fbad), .o_wake_sources_enabled(wen),
    .o_wake_flags_pending(wpend));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (load === 1'b1) loads <= loads + 1;
    if (wdr === 1'b1) wdrs <= wdrs + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      $display("ERROR timeout expected end seen hang");
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // wait for a mode under a bound, then compare
  task automatic go(input dmtc_pkg::dev_mode_type m, input int n);
    for (int i = 0; i < n && mode !== m; i++) step(1);
    chk("mode", {5'h00, m}, {5'h00, mode});
  endtask
  task automatic wait_rst(output int n);
    n = 0;
    while (rst_n !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
  endtask
  task automatic clear_all();
    flag_clr = 5'h1f;
    wake_clr = 6'h3f;
    step(1);
    flag_clr = 5'h00;
    wake_clr = 6'h00;
    exp_flags = 5'h00;
    step(1);
  endtask
  task automatic wd_case(input logic msk, input logic dis, input int irqs, input logic fl);
    wd_mask = msk;
    wd_dis = dis;
    irq0 = host_model_inst.irq_count;
    step(3);
    watchdog_failure_flag = 1'b1;
    step(1);
    watchdog_failure_flag = 1'b0;
    step(40);
    chk("wd_irq", irqs[7:0], host_model_inst.irq_count - irq0);
    chk("wd_flag", fl, flags[dmtc_pkg::FLAG_WATCHDOG_FAILURE_FLAG]);
    chk("wd_en", {7'h00, ~dis}, {7'h00, wd_en});
    chk("wd_mode", {5'h00, dmtc_pkg::ST_NORMAL}, {5'h00, mode});
    clear_all();
  endtask
  task automatic restart_back();
    wait_rst(k);
    b = wdrs;
    go(dmtc_pkg::ST_NORMAL, 4);
    step(1);
    chk("wd_restart", 8'h01, wdrs - b);
  endtask
  initial begin
    {arst_n, main_ok, supply_ok, thermal, short_gnd, sel, wd_dis, wd_mask, watchdog_failure_flag} = 9'h000;
    {ov, ovfs} = 2'h0;
    {main_uv, dev_sel, wake, wake_clr, flag_clr, exp_flags} = {2'h3, 6'h00, 6'h00, 10'h000};
    b = $urandom(32'h315c2ce0);
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    step(20);
    chk("rst_low", 8'h00, rst_n);
    main_ok = 1'b1;
    main_uv = 1'b0;
    wait_rst(k);
    chk("rst_delay", 8'h01, k >= 2500 && k < 2510);
    chk("flags_pwr", 8'h00, flags);
    chk("dev", 8'h07, {dev_act, canlin, wd_en});
    step(8);
    chk("supply_uv", 8'h01, flags[dmtc_pkg::FLAG_SUPPLY_UV]);
    supply_ok = 1'b1;
    step(4);
    clear_all();
    wake = 6'h01;
    step(8);
    chk("init_wake", 8'h00, wstat);
    go(dmtc_pkg::ST_INIT, 1);
    wake = 6'h00;
    host_model_inst.send(dmtc_pkg::MODE_SLEEP, 1'($urandom_range(1, 0)));
    go(dmtc_pkg::ST_NORMAL, 6);
    chk("spi_fail", 8'h01, flags[dmtc_pkg::FLAG_SPI_FAIL]);
    chk("canlin", 8'h01, canlin);
    clear_all();
    wd_case(1'b0, 1'b0, 1, 1'b1);
    wd_case(1'b1, 1'b0, 0, 1'b1);
    wd_case(1'b0, 1'b1, 0, 1'b0);
    wd_dis = 1'b0;
    irq0 = host_model_inst.irq_count;
    host_model_inst.wake_setup(1'b1, 1'b1);
    host_model_inst.send(dmtc_pkg::MODE_STOP, 1'b0);
    go(dmtc_pkg::ST_STOP, 6);
    step(4);
    chk("stop_irq", 8'h01, host_model_inst.irq_count - irq0);
    host_model_inst.wake_setup(1'b1, 1'b0);
    step(50);
    go(dmtc_pkg::ST_STOP, 1);
    host_model_inst.send(dmtc_pkg::MODE_NORMAL, 1'b0);
    go(dmtc_pkg::ST_NORMAL, 6);
    host_model_inst.send(dmtc_pkg::MODE_STOP, 1'b0);
    go(dmtc_pkg::ST_STOP, 6);
    host_model_inst.send(dmtc_pkg::MODE_SLEEP, 1'b0);
    go(dmtc_pkg::ST_RESTART, 6);
    chk("stop_sleep", 8'h01, flags[dmtc_pkg::FLAG_SPI_FAIL]);
    restart_back();
    clear_all();
    host_model_inst.wake_setup(1'b0, 1'b0);
    host_model_inst.send(dmtc_pkg::MODE_SLEEP, 1'b0);
    go(dmtc_pkg::ST_RESTART, 6);
    chk("no_src", 8'h01, flags[dmtc_pkg::FLAG_SPI_FAIL]);
    host_model_inst.wake_setup(1'b1, 1'b0);
    restart_back();
    clear_all();
    for (int s = 0; s < 2; s++) begin
      sel = 1'(s);
      b = loads;
      host_model_inst.send(dmtc_pkg::MODE_SOFT_RESET, 1'b0);
      go(dmtc_pkg::ST_INIT, 6);
      step(3);
      chk("soft_load", 8'h01, loads - b);
      chk("soft_rst", {7'h00, sel}, rst_n);
      wait_rst(k);
      host_model_inst.send(dmtc_pkg::MODE_NORMAL, 1'b0);
      go(dmtc_pkg::ST_NORMAL, 6);
    end
    main_uv = 1'b1;
    go(dmtc_pkg::ST_RESTART, 10);
    main_uv = 1'b0;
    exp_flags = 5'(1 << dmtc_pkg::FLAG_MAIN_UV) | 5'(1 << dmtc_pkg::FLAG_RESTART);
    chk("uv_flags", {3'h0, exp_flags}, {3'h0, flags});
    restart_back();
    clear_all();
    ov = 1'b1;
    go(dmtc_pkg::ST_RESTART, 10);
    ov = 1'b0;
    restart_back();
    clear_all();
    for (int w = 0; w < 6; w++) begin
      host_model_inst.send(dmtc_pkg::MODE_SLEEP, 1'b0);
      go(dmtc_pkg::ST_SLEEP, 6);
      step(2);
      chk("sleep_rst", 8'h00, rst_n);
      wake = 6'h01 << w;
      go(dmtc_pkg::ST_RESTART, 10);
      wake = 6'h00;
      chk("wake_src", {2'h0, 6'h01 << w}, wstat);
      chk("restart_flag", 8'h01, flags[dmtc_pkg::FLAG_RESTART]);
      chk("restart_rst", 8'h00, rst_n);
      restart_back();
      clear_all();
    end
    thermal = 1'b1;
    host_model_inst.send(dmtc_pkg::MODE_SLEEP, 1'b0);
    go(dmtc_pkg::ST_FAILSAFE, 10);
    arst_n = 1'b0;
    {thermal, main_ok, short_gnd} = 3'h0;
    step(6);
    arst_n = 1'b1;
    step(4);
    chk("dev_init", 8'h01, dev_act);
    short_gnd = 1'b1;
    go(dmtc_pkg::ST_FAILSAFE, 50);
    chk("dev_short", 8'h00, dev_act);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
